// ---- ctms_pkg.sv ----
// Constants, register map and types of the current and thermal monitor
// scheduler. Assumes a 125 MHz core clock and byte-wide registers.
package ctms_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 500;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int CUR_ACT0_US = 250000;
  localparam int CUR_ACT1_US = 500;
  localparam int CUR_ACT2_US = 1000;
  localparam int CUR_ACT3_US = 3000;
  localparam int CUR_STBY1_US = 1000;
  localparam int CUR_STBY2_US = 5000;
  localparam int CUR_STBY3_US = 10000;
  localparam int TH_ACT1_S = 5;
  localparam int TH_ACT2_S = 10;
  localparam int TH_ACT3_S = 30;
  localparam int TH_STBY_S = 30;
  localparam int US_PER_S = 1000000;
  localparam int PER_W = 16;
  localparam logic [3:0][PER_W-1:0] CUR_ACT_TICKS = {
    16'(CUR_ACT3_US / TICK_US), 16'(CUR_ACT2_US / TICK_US),
    16'(CUR_ACT1_US / TICK_US), 16'(CUR_ACT0_US / TICK_US)};
  localparam logic [3:0][PER_W-1:0] CUR_STBY_TICKS = {
    16'(CUR_STBY3_US / TICK_US), 16'(CUR_STBY2_US / TICK_US),
    16'(CUR_STBY1_US / TICK_US), 16'h0000};
  localparam logic [3:0][PER_W-1:0] TH_ACT_TICKS = {
    16'(TH_ACT3_S * US_PER_S / TICK_US), 16'(TH_ACT2_S * US_PER_S / TICK_US),
    16'(TH_ACT1_S * US_PER_S / TICK_US), 16'h0000};
  localparam logic [PER_W-1:0] TH_STBY_TICKS =
    16'(TH_STBY_S * US_PER_S / TICK_US);

  // ****************************************
  // Register map
  // ****************************************
  localparam int NRAIL = 5;
  localparam int RES_W = 10;
  localparam logic [7:0] CUR_CTL_ADDR = 8'h71;
  localparam logic [7:0] TH_CTL_ADDR = 8'h8e;
  localparam logic [7:0] CUR_POL_ADDR = 8'he3;
  localparam logic [7:0] TH_POL_ADDR = 8'he4;
  localparam logic [7:0] DIE_HI_ADDR = 8'h7e;
  localparam logic [7:0] DIE_LO_ADDR = 8'h7f;
  // Rail order: rail0, rail1, rail2, rail5, rail6
  localparam logic [NRAIL-1:0][7:0] RAIL_HI_ADDR =
    {8'h8a, 8'h88, 8'h8c, 8'h86, 8'h84};
  localparam logic [NRAIL-1:0][7:0] RAIL_LO_ADDR =
    {8'h8b, 8'h89, 8'h8d, 8'h87, 8'h85};
  localparam logic [7:0] LINK_CUR_REG = 8'h15;
  localparam int LINK_RAILS = 3;
  localparam logic [2:0] DIE_SEL = 3'h5;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CUR_EN_BIT = 0;
  localparam int CUR_FA_LSB = 1;
  localparam int CUR_FS_LSB = 3;
  localparam int CUR_MODE_BIT = 5;
  localparam int TH_EN_BIT = 0;
  localparam int TH_FA_LSB = 1;
  localparam int TH_FS_BIT = 3;
  localparam int TH_MODE_BIT = 4;
  localparam int POL_LSB = 4;
  localparam logic [7:0] CUR_CTL_RST = 8'h2b;
  localparam logic [7:0] TH_CTL_RST = 8'h15;
  localparam logic [7:0] POL_RST = 8'h30;

  typedef enum logic [1:0] {
    HOST_FULL_ON, HOST_IDLE_SUSPEND, HOST_SLEEP, HOST_OFF
  } ctms_host_state_type;

  typedef enum logic {ST_IDLE, ST_WAIT} ctms_state_type;

  // Standby when the host state falls in the policy's standby set
  function automatic logic ctms_is_standby(logic [1:0] pol,
                                           ctms_host_state_type st);
    logic r;
    r = 1'b0;
    case (pol)
      2'h1: r = (st == HOST_OFF);
      2'h2: r = (st == HOST_OFF) || (st == HOST_SLEEP);
      2'h3: r = (st != HOST_FULL_ON);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// ---- ctms_interval_timer.sv ----
// Interval timer counting slow ticks; one expiry pulse per period.
// Assumes tick is a one-cycle enable from the scheduler's divider.
`timescale 1ns/1ps
module ctms_interval_timer #(
  parameter int PW = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [PW-1:0] period,
  output logic expire
);
  import ctms_pkg::*;

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic expire;
  } ctms_tmr_type;

  ctms_tmr_type s_r;
  ctms_tmr_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (restart) begin
      s_nxt.cnt = '0;
    end else if (run && tick && period != '0) begin
      // Count compares against period-1 so a change down never overruns
      if (s_r.cnt >= period - 1'b1) begin
        s_nxt.cnt = '0;
        s_nxt.expire = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expire = s_r.expire;

endmodule

// ---- ctms_scheduler.sv ----
// Current and thermal monitor scheduler: registers, interval timers,
// conversion sequencing and result storage.
// Assumes a shared converter answering each request with conv_done.
// Operation
// RULE_01 - Five rails are measured, each with its own result pair.
// RULE_02 - High result register holds result bits 9 down to 2.
// RULE_03 - Low result register holds bits 1:0, reads zero, rest reserved.
// RULE_04 - Rail pairs sit at 84/85, 86/87, 8C/8D, 88/89, 8A/8B.
// RULE_05 - Link register 15 returns current of rail selected by address.
// RULE_06 - Active current interval: 0.25s, 0.5ms, 1ms, 3ms.
// RULE_07 - Standby current interval: off, 1ms, 5ms, 10ms.
// RULE_08 - Current mode bit is read-only; its change restarts timers.
// RULE_09 - Current enable gates timers; writing one restarts them.
// RULE_10 - Current policy maps host states to active or standby.
// RULE_11 - Thermal mode bit is read-only; its change restarts timers.
// RULE_12 - Standby thermal: zero disables, one measures every 30s.
// RULE_13 - Active thermal interval: off, 5s, 10s, 30s.
// RULE_14 - Thermal enable gates timers; writing one restarts them.
// RULE_15 - Critical shutdown works regardless of thermal enable.
// RULE_16 - Thermal policy uses the same encodings, reset value 11.
// RULE_17 - Die result: bits 9:8 high register, bits 7:0 low.
// RULE_18 - Each timed die result is compared with the alert threshold.
// RULE_19 - Each expiry issues conversions; results stored on completion.
// RULE_20 - Zero interval stops timer until interval or mode changes.
`timescale 1ns/1ps
module ctms_scheduler #(
  parameter int TICK_CYC = ctms_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire ctms_pkg::ctms_host_state_type host_state,
  output logic conv_req,
  output logic [2:0] conv_sel,
  input wire logic conv_done,
  input wire logic [ctms_pkg::RES_W-1:0] conv_data,
  input wire logic link_rd,
  input wire logic [7:0] link_reg,
  input wire logic [1:0] link_addr,
  output logic [ctms_pkg::RES_W-1:0] link_rdata,
  output logic link_valid,
  input wire logic [ctms_pkg::RES_W-1:0] die_alert_threshold,
  output logic die_alert,
  input wire logic die_critical,
  output logic shutdown_req
);
  import ctms_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [16:0] div;
    logic tick;
    logic cur_en;
    logic [1:0] cur_fa;
    logic [1:0] cur_fs;
    logic cur_mode;
    logic [1:0] cur_pol;
    logic [PER_W-1:0] cur_per;
    logic th_en;
    logic [1:0] th_fa;
    logic th_fs;
    logic th_mode;
    logic [1:0] th_pol;
    logic [PER_W-1:0] th_per;
    logic [NRAIL-1:0][RES_W-1:0] rail_res;
    logic [RES_W-1:0] die_res;
    logic cur_pend;
    logic die_pend;
    ctms_state_type state;
    logic conv_req;
    logic [2:0] conv_sel;
    logic [7:0] rdata;
    logic [RES_W-1:0] link_rdata;
    logic link_valid;
    logic die_alert;
    logic shutdown;
  } ctms_state_regs_type;

  ctms_state_regs_type s_r;
  ctms_state_regs_type s_nxt;

  logic cur_stby_w;
  logic th_stby_w;
  logic [PER_W-1:0] cur_period_w;
  logic [PER_W-1:0] th_period_w;
  logic cur_en_set_w;
  logic th_en_set_w;
  logic cur_restart;
  logic th_restart;
  logic cur_exp;
  logic th_exp;

  // ****************************************
  // Modes, intervals and timers
  // ****************************************
  assign cur_stby_w = ctms_is_standby(s_r.cur_pol, host_state); // RULE_10
  assign th_stby_w = ctms_is_standby(s_r.th_pol, host_state); // RULE_16
  // Encoding 00 yields period zero and halts the timer, except active current, where 00 gives 0.25s
  assign cur_period_w = s_r.cur_mode ? CUR_STBY_TICKS[s_r.cur_fs] // RULE_07
                                     : CUR_ACT_TICKS[s_r.cur_fa]; // RULE_06
  assign th_period_w = s_r.th_mode ? (s_r.th_fs ? TH_STBY_TICKS // RULE_12
                                                : '0)
                                   : TH_ACT_TICKS[s_r.th_fa]; // RULE_13
  assign cur_en_set_w = reg_wr && reg_addr == CUR_CTL_ADDR
                        && reg_wdata[CUR_EN_BIT];
  assign th_en_set_w = reg_wr && reg_addr == TH_CTL_ADDR
                       && reg_wdata[TH_EN_BIT];
  assign cur_restart = (cur_stby_w != s_r.cur_mode) // RULE_08
                       || cur_en_set_w // RULE_09
                       || (cur_period_w != s_r.cur_per); // RULE_20
  assign th_restart = (th_stby_w != s_r.th_mode) // RULE_11
                      || th_en_set_w // RULE_14
                      || (th_period_w != s_r.th_per); // RULE_20

  ctms_interval_timer #(.PW(PER_W)) u_cur_tmr (
    .clk(clk),
    .nrst(nrst),
    .tick(s_r.tick),
    .run(s_r.cur_en),
    .restart(cur_restart),
    .period(cur_period_w),
    .expire(cur_exp)
  );

  ctms_interval_timer #(.PW(PER_W)) u_th_tmr (
    .clk(clk),
    .nrst(nrst),
    .tick(s_r.tick),
    .run(s_r.th_en),
    .restart(th_restart),
    .period(th_period_w),
    .expire(th_exp)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.conv_req = 1'b0;
    s_nxt.link_valid = 1'b0;
    if (s_r.div >= 17'(TICK_CYC - 1)) begin
      s_nxt.div = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 17'h00001;
    end
    s_nxt.cur_mode = cur_stby_w; // RULE_08
    s_nxt.th_mode = th_stby_w; // RULE_11
    s_nxt.cur_per = cur_period_w;
    s_nxt.th_per = th_period_w;
    // Independent of enable and timers so it can never be masked
    s_nxt.shutdown = die_critical; // RULE_15

    if (reg_wr) begin
      case (reg_addr)
        CUR_CTL_ADDR: begin
          s_nxt.cur_en = reg_wdata[CUR_EN_BIT]; // RULE_09
          s_nxt.cur_fa = reg_wdata[CUR_FA_LSB +: 2];
          s_nxt.cur_fs = reg_wdata[CUR_FS_LSB +: 2];
        end
        TH_CTL_ADDR: begin
          s_nxt.th_en = reg_wdata[TH_EN_BIT]; // RULE_14
          s_nxt.th_fa = reg_wdata[TH_FA_LSB +: 2];
          s_nxt.th_fs = reg_wdata[TH_FS_BIT];
        end
        CUR_POL_ADDR: s_nxt.cur_pol = reg_wdata[POL_LSB +: 2];
        TH_POL_ADDR: s_nxt.th_pol = reg_wdata[POL_LSB +: 2];
        default: ;
      endcase
    end

    if (reg_rd) begin
      s_nxt.rdata = 8'h00;
      case (reg_addr)
        CUR_CTL_ADDR: begin
          s_nxt.rdata[CUR_EN_BIT] = s_r.cur_en;
          s_nxt.rdata[CUR_FA_LSB +: 2] = s_r.cur_fa;
          s_nxt.rdata[CUR_FS_LSB +: 2] = s_r.cur_fs;
          s_nxt.rdata[CUR_MODE_BIT] = s_r.cur_mode;
        end
        TH_CTL_ADDR: begin
          s_nxt.rdata[TH_EN_BIT] = s_r.th_en;
          s_nxt.rdata[TH_FA_LSB +: 2] = s_r.th_fa;
          s_nxt.rdata[TH_FS_BIT] = s_r.th_fs;
          s_nxt.rdata[TH_MODE_BIT] = s_r.th_mode;
        end
        CUR_POL_ADDR: s_nxt.rdata[POL_LSB +: 2] = s_r.cur_pol;
        TH_POL_ADDR: s_nxt.rdata[POL_LSB +: 2] = s_r.th_pol;
        DIE_HI_ADDR: s_nxt.rdata[1:0] = s_r.die_res[9:8]; // RULE_17
        DIE_LO_ADDR: s_nxt.rdata = s_r.die_res[7:0]; // RULE_17
        default: begin
          for (int i = 0; i < NRAIL; i++) begin
            if (reg_addr == RAIL_HI_ADDR[i]) begin // RULE_04
              s_nxt.rdata = s_r.rail_res[i][9:2]; // RULE_02
            end
            // Low register reads zero; result bits 1:0 are stored but not returned
            if (reg_addr == RAIL_LO_ADDR[i]) begin // RULE_04
              s_nxt.rdata = 8'h00; // RULE_03
            end
          end
        end
      endcase
    end

    if (link_rd) begin
      s_nxt.link_valid = 1'b1;
      s_nxt.link_rdata = '0;
      if (link_reg == LINK_CUR_REG && 32'(link_addr) < LINK_RAILS) begin
        s_nxt.link_rdata = s_r.rail_res[link_addr]; // RULE_05
      end
    end

    // Set wins over the clear taken by the sequencer
    s_nxt.cur_pend = s_r.cur_pend || cur_exp;
    s_nxt.die_pend = s_r.die_pend || th_exp;
    case (s_r.state)
      ST_IDLE: begin
        if (s_r.cur_pend) begin
          s_nxt.cur_pend = cur_exp;
          s_nxt.conv_sel = 3'h0;
          s_nxt.conv_req = 1'b1; // RULE_19
          s_nxt.state = ST_WAIT;
        end else if (s_r.die_pend) begin
          s_nxt.die_pend = th_exp;
          s_nxt.conv_sel = DIE_SEL;
          s_nxt.conv_req = 1'b1; // RULE_19
          s_nxt.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (conv_done) begin
          if (s_r.conv_sel == DIE_SEL) begin
            s_nxt.die_res = conv_data; // RULE_17
            s_nxt.die_alert = conv_data >= die_alert_threshold; // RULE_18
            s_nxt.state = ST_IDLE;
          end else begin
            s_nxt.rail_res[s_r.conv_sel] = conv_data; // RULE_01
            if (32'(s_r.conv_sel) < NRAIL - 1) begin
              s_nxt.conv_sel = s_r.conv_sel + 3'h1;
              s_nxt.conv_req = 1'b1; // RULE_19
            end else begin
              s_nxt.state = ST_IDLE;
            end
          end
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.cur_en <= CUR_CTL_RST[CUR_EN_BIT];
      s_r.cur_fa <= CUR_CTL_RST[CUR_FA_LSB +: 2];
      s_r.cur_fs <= CUR_CTL_RST[CUR_FS_LSB +: 2];
      s_r.cur_mode <= CUR_CTL_RST[CUR_MODE_BIT];
      s_r.cur_pol <= POL_RST[POL_LSB +: 2];
      s_r.th_en <= TH_CTL_RST[TH_EN_BIT];
      s_r.th_fa <= TH_CTL_RST[TH_FA_LSB +: 2];
      s_r.th_fs <= TH_CTL_RST[TH_FS_BIT];
      s_r.th_mode <= TH_CTL_RST[TH_MODE_BIT];
      s_r.th_pol <= POL_RST[POL_LSB +: 2];
      s_r.state <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign conv_req = s_r.conv_req;
  assign conv_sel = s_r.conv_sel;
  assign link_rdata = s_r.link_rdata;
  assign link_valid = s_r.link_valid;
  assign die_alert = s_r.die_alert;
  assign shutdown_req = s_r.shutdown;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_REQ_PULSE: assert property (conv_req |=> !conv_req) // RULE_19
    else $error("conversion request held longer than one cycle");
  AST_RES_ON_DONE: assert property ( // RULE_19
    !conv_done |=> $stable(s_r.rail_res) && $stable(s_r.die_res))
    else $error("result changed without a conversion completing");
  AST_HI_READ: assert property ( // RULE_02
    reg_rd && reg_addr == 8'h84 |=> reg_rdata == $past(s_r.rail_res[0][9:2]))
    else $error("rail0 high register read wrong bits");
  AST_LO_ZERO: assert property ( // RULE_03
    reg_rd && reg_addr == 8'h8d |=> reg_rdata == 8'h00)
    else $error("low current register not zero");
  AST_MODE_RESTART: assert property ( // RULE_08
    $changed(s_r.cur_mode) |-> $past(cur_restart))
    else $error("current mode changed without timer restart");
  AST_TH_MODE: assert property ( // RULE_16
    ##1 s_r.th_mode == $past(th_stby_w))
    else $error("thermal mode does not follow policy");
  AST_EN_GATE: assert property ( // RULE_09
    !s_r.cur_en && $past(!s_r.cur_en) |-> !cur_exp)
    else $error("current timer expired while disabled");
  AST_ZERO_STOP: assert property ( // RULE_20
    th_period_w == '0 && $past(th_period_w) == '0 |-> !th_exp)
    else $error("thermal timer expired with zero interval");
  AST_SHUTDOWN: assert property ( // RULE_15
    die_critical |=> shutdown_req)
    else $error("critical temperature did not request shutdown");
  AST_LINK: assert property ( // RULE_05
    link_rd && link_reg == 8'h15 && link_addr == 2'h1
    |=> link_valid && link_rdata == $past(s_r.rail_res[1]))
    else $error("link read returned wrong rail current");
  AST_ALERT: assert property ( // RULE_18
    s_r.state == ST_WAIT && conv_done && s_r.conv_sel == 3'h5
    |=> die_alert == ($past(conv_data) >= $past(die_alert_threshold)))
    else $error("die alert compare wrong after measurement");

endmodule

// ---- ctms_conv_model.sv ----
// Behavioural model of the shared converter behind the scheduler.
// Assumes one request in flight; answers after lat cycles (1 or more).
`timescale 1ns/1ps
module ctms_conv_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic conv_req,
  input wire logic [2:0] conv_sel,
  input wire logic [7:0] lat,
  input wire logic [9:0] base,
  output logic conv_done,
  output logic [9:0] conv_data
);
  // ****************************************
  // Conversion sequencing
  // ****************************************
  logic busy_r;
  logic [7:0] cnt_r;
  logic [2:0] sel_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      sel_r <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      // Data toggles outside done so a stale sample never looks valid
      conv_data <= ~conv_data;
      if (busy_r) begin
        if (cnt_r <= 8'h01) begin
          conv_done <= 1'b1;
          conv_data <= base + 10'(sel_r * 10'h053);
          busy_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end else if (conv_req) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
        sel_r <= conv_sel;
      end
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the monitor scheduler with converter model.
// Assumes TICK_CYC shortened to 4 cycles; inputs change at falling edge.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  import ctms_pkg::*;
  localparam int TC = 4;
  localparam logic [9:0] BASE = 10'h1a5;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  ctms_host_state_type host_state = HOST_OFF;
  logic conv_req;
  logic [2:0] conv_sel;
  logic conv_done;
  logic [9:0] conv_data;
  logic link_rd = 1'b0;
  logic [7:0] link_reg = 8'h00;
  logic [1:0] link_addr = 2'h0;
  logic [9:0] link_rdata;
  logic link_valid;
  logic [9:0] die_alert_threshold = 10'h3ff;
  logic die_alert;
  logic die_critical = 1'b0;
  logic shutdown_req;
  logic [7:0] lat = 8'd60;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;

  ctms_scheduler #(.TICK_CYC(TC)) i_dut (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_state(host_state),
    .conv_req(conv_req), .conv_sel(conv_sel), .conv_done(conv_done),
    .conv_data(conv_data), .link_rd(link_rd), .link_reg(link_reg),
    .link_addr(link_addr), .link_rdata(link_rdata),
    .link_valid(link_valid), .die_alert_threshold(die_alert_threshold),
    .die_alert(die_alert), .die_critical(die_critical),
    .shutdown_req(shutdown_req));
  ctms_conv_model i_conv (.clk(clk), .nrst(nrst), .conv_req(conv_req),
    .conv_sel(conv_sel), .lat(lat), .base(BASE), .conv_done(conv_done),
    .conv_data(conv_data));

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [9:0] mval(int s);
    return BASE + 10'(s * 10'h053);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, e)
  endtask
  task automatic wait_req(input logic [2:0] s, input int lim, output int t);
    t = -1;
    for (int i = 0; i < lim && t < 0; i++) begin
      @(negedge clk);
      if (conv_req === 1'b1 && conv_sel === s) t = cyc;
    end
    if (t < 0) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      report_and_stop();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (int i = 0; i < NRAIL; i++) begin
      rd_chk(RAIL_HI_ADDR[i], 8'h00);
      rd_chk(RAIL_LO_ADDR[i], 8'h00);
    end
    rd_chk(8'h71, 8'h2b);
    rd_chk(8'h8e, 8'h15);
    rd_chk(8'he3, 8'h30);
    rd_chk(8'he4, 8'h30);
    rd_chk(8'h00, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_results();
    int t;
    logic [9:0] v;
    lat = 8'd1;
    wait_req(3'h4, 3000, t);
    repeat (4) @(negedge clk);
    for (int i = 0; i < NRAIL; i++) begin
      v = mval(i);
      rd_chk(RAIL_HI_ADDR[i], v[9:2]);
      rd_chk(RAIL_LO_ADDR[i], 8'h00);
    end
    wr(8'h84, 8'hff);
    v = mval(0);
    rd_chk(8'h84, v[9:2]);
    $display("test results done");
  endtask
  task automatic t_link();
    for (int a = 0; a < 5; a++) begin
      @(negedge clk);
      link_rd = 1'b1;
      link_reg = (a == 4) ? 8'h14 : 8'h15;
      link_addr = (a == 4) ? 2'h0 : 2'(a);
      @(negedge clk);
      link_rd = 1'b0;
      `CHK(link_valid, 1'b1)
      `CHK(link_rdata, (a < 3) ? mval(a) : 10'h000)
    end
    $display("test link done");
  endtask
  task automatic t_policy();
    logic sb;
    for (int p = 0; p < 4; p++) begin
      for (int h = 0; h < 4; h++) begin
        host_state = ctms_host_state_type'(h);
        sb = (p == 1 && h == 3) || (p == 2 && h >= 2) || (p == 3 && h != 0);
        wr(8'he3, 8'(p << 4));
        wr(8'he4, 8'(p << 4));
        rd_chk(8'h71, {2'b00, sb, 5'h0b});
        rd_chk(8'h8e, {3'b000, sb, 4'h5});
        rd_chk(8'he4, 8'(p << 4));
      end
    end
    host_state = HOST_FULL_ON;
    wr(8'he3, 8'h30);
    wr(8'he4, 8'h30);
    wr(8'h71, 8'h2b);
    wr(8'h8e, 8'h15);
    rd_chk(8'h71, 8'h0b);
    rd_chk(8'h8e, 8'h05);
    $display("test policy done");
  endtask
  task automatic t_intervals();
    logic [7:0] ctl [4] = '{8'h0f, 8'h09, 8'h13, 8'h1b};
    int ex [4] = '{6 * TC, 500 * TC, 10 * TC, 20 * TC};
    int t0;
    int t1;
    int n;
    for (int k = 0; k < 4; k++) begin
      host_state = (k < 2) ? HOST_FULL_ON : HOST_OFF;
      // Drain queued batches first, else t0 is not aligned to the restart
      wr(8'h71, ctl[k] & 8'hfe);
      repeat (40) @(negedge clk);
      wr(8'h71, ctl[k]);
      wait_req(3'h0, 3000, t0);
      wait_req(3'h0, 3000, t1);
      `CHK(t1 - t0, ex[k])
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h71, (k == 0) ? 8'h03 : 8'h1a);
      repeat (30) @(negedge clk);
      n = 0;
      repeat (300) begin
        @(negedge clk);
        if (conv_req !== 1'b0) n++;
      end
      `CHK(n, 0)
    end
    $display("test intervals done");
  endtask
  task automatic t_thermal();
    int t0;
    int t1;
    logic [9:0] v;
    v = mval(5);
    host_state = HOST_FULL_ON;
    die_alert_threshold = v;
    wr(8'h71, 8'h0a);
    wr(8'h8e, 8'h03);
    t0 = cyc;
    wait_req(DIE_SEL, 41000, t1);
    `CHK(t1 - t0 >= 39992 && t1 - t0 <= 40008, 1'b1)
    repeat (4) @(negedge clk);
    rd_chk(8'h7e, {6'h00, v[9:8]});
    rd_chk(8'h7f, v[7:0]);
    `CHK(die_alert, 1'b1)
    wr(8'h8e, 8'h00);
    @(negedge clk);
    die_critical = 1'b1;
    @(negedge clk);
    @(negedge clk);
    `CHK(shutdown_req, 1'b1)
    die_critical = 1'b0;
    $display("test thermal done");
  endtask

  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_results();
    t_link();
    t_policy();
    t_intervals();
    t_thermal();
    report_and_stop();
  end
endmodule
